// *** logic/mvtim_regs.svh ***
`ifndef MVTIM_REGS_SVH
`define MVTIM_REGS_SVH
// Functional notes
// - High-word load keeps low half; 5B/3 states binary, 4B/2 source.
// - Sign-extend byte into word; 2 states binary, 1 state source.
// - Zero-extend byte into word; 3 bytes/2 states binary, 2/1 source.
// - Code read at accumulator plus data pointer; 1 byte, 6 states.
// - Code read at accumulator plus program counter; 6 states.
// - External moves use region register, which resets to 01h.
// - External read by index byte: 4 states binary, 5 source.
// - External read by data pointer: 3 states, plus N+2 if external.
// - External write by index byte: 4 states in both modes.
// - External write by data pointer: 4 states, plus N+1 if external.
// - Code reads and pointer writes to external add N+1 states.
// - Pointer external read to external location adds N+2 states.
// - Direct port operand adds 1 state; peripheral register adds 2.
// - Direct-to-direct: 3 bytes, 3 states, penalty per operand.
// - Index to accumulator: 2 states/1 byte binary, 3/2 source.
// - Accumulator through index register: 3 states binary, 4 source.
// - Data pointer immediate load: 3 bytes, 2 states both modes.
// - Immediate to direct: 3 bytes, 3 states before any penalty.
// - Accumulator to direct 2 states; working reg 2 binary, 3 source.
`define MVTIM_REGION_RESET 8'h01
`define MVTIM_PORT_EXTRA   4'h1
`define MVTIM_PERIPH_EXTRA 4'h2
`define MVTIM_CNT_W        5
`endif

// *** logic/mvtim_pkg.sv ***
package mvtim_pkg;
  typedef enum logic [4:0] {
    MVTIM_OP_HIGH_WORD,
    MVTIM_OP_SIGN_EXT,
    MVTIM_OP_ZERO_EXT,
    MVTIM_OP_CODE_DATA_POINTER_16,
    MVTIM_OP_CODE_PC,
    MVTIM_OP_XRD_INDEX,
    MVTIM_OP_XRD_DATA_POINTER_16,
    MVTIM_OP_XWR_INDEX,
    MVTIM_OP_XWR_DATA_POINTER_16,
    MVTIM_OP_A_REG,
    MVTIM_OP_A_DIR,
    MVTIM_OP_A_IND,
    MVTIM_OP_A_IMM,
    MVTIM_OP_REG_A,
    MVTIM_OP_REG_DIR,
    MVTIM_OP_REG_IMM,
    MVTIM_OP_DIR_A,
    MVTIM_OP_DIR_REG,
    MVTIM_OP_DIR_DIR,
    MVTIM_OP_DIR_IND,
    MVTIM_OP_DIR_IMM,
    MVTIM_OP_IND_A,
    MVTIM_OP_IND_DIR,
    MVTIM_OP_IND_IMM,
    MVTIM_OP_DATA_POINTER_16_IMM
  } mvtim_op_t;
  typedef enum logic [1:0] {
    MVTIM_TGT_RAM,
    MVTIM_TGT_PORT,
    MVTIM_TGT_PERIPH
  } mvtim_tgt_t;
  typedef struct packed {
    mvtim_op_t  op;
    logic       source_mode;
    logic       ext_location;
    mvtim_tgt_t dir_a;
    mvtim_tgt_t dir_b;
    logic [31:0] dword_register;
    logic [15:0] word_register;
    logic [7:0]  general_byte_register;
    logic [15:0] immediate;
    logic [7:0]  accumulator;
    logic [15:0] data_pointer_16;
    logic [15:0] program_counter;
    logic [7:0]  index_byte_register;
  } mvtim_req_t;
  typedef struct packed {
    logic [31:0] dword_result;
    logic [15:0] word_result;
    logic [7:0]  acc_result;
    logic [23:0] mem_address;
    logic        code_access;
    logic        mem_write;
    logic [3:0]  bytes;
    logic [4:0]  states;
  } mvtim_rsp_t;
endpackage : mvtim_pkg

// *** logic/mvtim_core.sv ***
`timescale 1ns/1ps
`include "mvtim_regs.svh"
module mvtim_core #(
  parameter logic [3:0] WAIT_STATES_N = 4'h0
) (
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  input  wire logic              start_in,
  input  wire mvtim_pkg::mvtim_req_t req_in,
  input  wire logic              region_we_in,
  input  wire logic [7:0]        region_data_in,
  input  wire logic [7:0]        code_byte_in,
  input  wire logic [7:0]        xdata_byte_in,
  output logic                   busy_out,
  output logic                   done_out,
  output logic [7:0]             external_region_select_out,
  output mvtim_pkg::mvtim_rsp_t  rsp_out
);
  import mvtim_pkg::*;

  typedef enum logic [1:0] {MVTIM_IDLE, MVTIM_EXEC, MVTIM_FINISH} mvtim_st_t;

  // Direct-operand penalty; one call per operand keeps the dir-dir case honest.
  function automatic logic [3:0] dir_extra(input mvtim_tgt_t t);
    unique case (t)
      MVTIM_TGT_PORT:   dir_extra = `MVTIM_PORT_EXTRA;
      MVTIM_TGT_PERIPH: dir_extra = `MVTIM_PERIPH_EXTRA;
      default:          dir_extra = 4'h0;
    endcase
  endfunction : dir_extra

  // Base states and bytes chosen by execution mode.
  function automatic logic [7:0] base_cost(input mvtim_op_t op,
                                           input logic src);
    logic [3:0] b;
    logic [3:0] s;
    b = 4'h1;
    s = 4'h1;
    unique case (op)
      MVTIM_OP_HIGH_WORD: begin
        b = src ? 4'h4 : 4'h5;
        s = src ? 4'h2 : 4'h3;
      end
      MVTIM_OP_SIGN_EXT: begin
        b = src ? 4'h2 : 4'h3;
        s = src ? 4'h1 : 4'h2;
      end
      MVTIM_OP_ZERO_EXT: begin
        b = src ? 4'h2 : 4'h3;
        s = src ? 4'h1 : 4'h2;
      end
      MVTIM_OP_CODE_DATA_POINTER_16: begin
        b = 4'h1;
        s = 4'h6;
      end
      MVTIM_OP_CODE_PC: begin
        b = 4'h1;
        s = 4'h6;
      end
      MVTIM_OP_XRD_INDEX: begin
        b = 4'h1;
        s = src ? 4'h5 : 4'h4;
      end
      MVTIM_OP_XRD_DATA_POINTER_16: begin
        b = 4'h1;
        s = 4'h3;
      end
      MVTIM_OP_XWR_INDEX: begin
        b = 4'h1;
        s = 4'h4;
      end
      MVTIM_OP_XWR_DATA_POINTER_16: begin
        b = 4'h1;
        s = 4'h4;
      end
      MVTIM_OP_A_REG: begin
        b = src ? 4'h2 : 4'h1;
        s = src ? 4'h2 : 4'h1;
      end
      MVTIM_OP_A_DIR: begin
        b = 4'h2;
        s = 4'h1;
      end
      MVTIM_OP_A_IND: begin
        b = src ? 4'h2 : 4'h1;
        s = src ? 4'h3 : 4'h2;
      end
      MVTIM_OP_A_IMM: begin
        b = 4'h2;
        s = 4'h1;
      end
      MVTIM_OP_REG_A: begin
        b = src ? 4'h2 : 4'h1;
        s = src ? 4'h2 : 4'h1;
      end
      MVTIM_OP_REG_DIR: begin
        b = src ? 4'h3 : 4'h2;
        s = src ? 4'h2 : 4'h1;
      end
      MVTIM_OP_REG_IMM: begin
        b = src ? 4'h3 : 4'h2;
        s = src ? 4'h2 : 4'h1;
      end
      MVTIM_OP_DIR_A: begin
        b = 4'h2;
        s = 4'h2;
      end
      MVTIM_OP_DIR_REG: begin
        b = src ? 4'h3 : 4'h2;
        s = src ? 4'h3 : 4'h2;
      end
      MVTIM_OP_DIR_DIR: begin
        b = 4'h3;
        s = 4'h3;
      end
      MVTIM_OP_DIR_IND: begin
        b = src ? 4'h3 : 4'h2;
        s = src ? 4'h4 : 4'h3;
      end
      MVTIM_OP_DIR_IMM: begin
        b = 4'h3;
        s = 4'h3;
      end
      MVTIM_OP_IND_A: begin
        b = src ? 4'h2 : 4'h1;
        s = src ? 4'h4 : 4'h3;
      end
      MVTIM_OP_IND_DIR: begin
        b = src ? 4'h3 : 4'h2;
        s = src ? 4'h4 : 4'h3;
      end
      MVTIM_OP_IND_IMM: begin
        b = src ? 4'h3 : 4'h2;
        s = src ? 4'h4 : 4'h3;
      end
      MVTIM_OP_DATA_POINTER_16_IMM: begin
        b = 4'h3;
        s = 4'h2;
      end
      default: begin
        b = 4'h1;
        s = 4'h1;
      end
    endcase
    base_cost = {b, s};
  endfunction : base_cost

  mvtim_st_t             state;
  mvtim_st_t             next_state;
  mvtim_req_t            req;
  logic [`MVTIM_CNT_W-1:0] count;
  logic [`MVTIM_CNT_W-1:0] next_count;
  logic [7:0]            region;
  mvtim_rsp_t            next_rsp;

  // Decode of the latched request; all selection stays combinational.
  wire logic [7:0] cost_w   = base_cost(req.op, req.source_mode);
  wire logic [3:0] bytes_w  = cost_w[7:4];
  wire logic [3:0] base_w   = cost_w[3:0];
  wire logic       uses_dir = (req.op == MVTIM_OP_A_DIR)
                            || (req.op == MVTIM_OP_REG_DIR)
                            || (req.op == MVTIM_OP_DIR_A)
                            || (req.op == MVTIM_OP_DIR_REG)
                            || (req.op == MVTIM_OP_DIR_DIR)
                            || (req.op == MVTIM_OP_DIR_IND)
                            || (req.op == MVTIM_OP_DIR_IMM)
                            || (req.op == MVTIM_OP_IND_DIR);
  wire logic [3:0] pen_a    = uses_dir
                            ? dir_extra(req.dir_a) : 4'h0;
  wire logic [3:0] pen_b    = (req.op == MVTIM_OP_DIR_DIR)
                            ? dir_extra(req.dir_b) : 4'h0;
  wire logic       plus_one = req.ext_location
                            && ((req.op == MVTIM_OP_CODE_DATA_POINTER_16)
                            || (req.op == MVTIM_OP_CODE_PC)
                            || (req.op == MVTIM_OP_XWR_DATA_POINTER_16));
  wire logic       plus_two = req.ext_location
                            && (req.op == MVTIM_OP_XRD_DATA_POINTER_16);
  wire logic [4:0] wait_w   = {1'b0, WAIT_STATES_N};
  wire logic [4:0] ext_add  = plus_two ? 5'(wait_w + 5'h02)
                            : plus_one ? 5'(wait_w + 5'h01) : 5'h00;
  wire logic [4:0] total_w  = 5'({1'b0, base_w} + {1'b0, pen_a}
                            + {1'b0, pen_b} + ext_add);
  // Addresses: code reads add the accumulator to a 16-bit base.
  wire logic [15:0] code_base = (req.op == MVTIM_OP_CODE_PC)
                              ? req.program_counter : req.data_pointer_16;
  wire logic [15:0] code_addr = 16'(code_base
                              + {8'h00, req.accumulator});
  wire logic        x_index   = (req.op == MVTIM_OP_XRD_INDEX)
                              || (req.op == MVTIM_OP_XWR_INDEX);
  wire logic        x_any     = x_index || (req.op == MVTIM_OP_XRD_DATA_POINTER_16)
                              || (req.op == MVTIM_OP_XWR_DATA_POINTER_16);
  wire logic [23:0] x_addr    = x_index
                              ? {region, 8'h00, req.index_byte_register}
                              : {region, req.data_pointer_16};
  wire logic        is_code   = (req.op == MVTIM_OP_CODE_DATA_POINTER_16)
                              || (req.op == MVTIM_OP_CODE_PC);
  wire logic        is_xread  = (req.op == MVTIM_OP_XRD_INDEX)
                              || (req.op == MVTIM_OP_XRD_DATA_POINTER_16);
  wire logic [7:0]  gb        = req.general_byte_register;

  // Result selection; the dword keeps its low half on a high-word load.
  always_comb begin
    next_rsp = rsp_out;
    next_rsp.bytes = bytes_w;
    next_rsp.states = total_w;
    next_rsp.code_access = is_code;
    next_rsp.mem_write = (req.op == MVTIM_OP_XWR_INDEX)
                      || (req.op == MVTIM_OP_XWR_DATA_POINTER_16);
    next_rsp.mem_address = is_code ? {8'h00, code_addr}
                         : (x_any ? x_addr : 24'h000000);
    next_rsp.dword_result = {req.immediate,
                             req.dword_register[15:0]};
    next_rsp.word_result = (req.op == MVTIM_OP_SIGN_EXT)
                         ? {{8{gb[7]}}, gb}
                         : {8'h00, gb};
    next_rsp.acc_result = is_code ? code_byte_in
                        : (is_xread ? xdata_byte_in : req.accumulator);
  end

  // Sequencer: one clock per state period, counting down the total.
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      MVTIM_IDLE: begin
        if (start_in) begin
          next_state = MVTIM_EXEC;
        end
      end
      MVTIM_EXEC: begin
        if (count == '0) begin
          next_count = 5'(total_w - 5'h01);
          next_state = (total_w == 5'h01) ? MVTIM_FINISH : MVTIM_EXEC;
        end else if (count == 5'h01) begin
          next_count = '0;
          next_state = MVTIM_FINISH;
        end else begin
          next_count = 5'(count - 5'h01);
        end
      end
      MVTIM_FINISH: begin
        next_state = MVTIM_IDLE;
        next_count = '0;
      end
    endcase
  end

  // Request capture happens only when idle so operands stay stable.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req <= '0;
    end else if (state == MVTIM_IDLE && start_in) begin
      req <= req_in;
    end
  end

  // Region register; the bus-side write is taken any time.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      region <= `MVTIM_REGION_RESET;
    end else if (region_we_in) begin
      region <= region_data_in;
    end
  end

  // State and outputs, all registered.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= MVTIM_IDLE;
      count <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rsp_out <= '0;
      external_region_select_out <= `MVTIM_REGION_RESET;
    end else begin
      state <= next_state;
      count <= next_count;
      busy_out <= (next_state != MVTIM_IDLE);
      done_out <= (next_state == MVTIM_FINISH);
      external_region_select_out <= region_we_in ? region_data_in : region;
      if (next_state == MVTIM_FINISH) begin
        rsp_out <= next_rsp;
      end
    end
  end

  // Cycles spent in EXEC for the running instruction.
  logic [5:0] exec_len;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      exec_len <= '0;
    end else if (state == MVTIM_EXEC) begin
      exec_len <= 6'(exec_len + 6'h01);
    end else begin
      exec_len <= '0;
    end
  end

  a_len_matches: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (state == MVTIM_EXEC && next_state == MVTIM_FINISH)
      |-> (exec_len + 6'h01) == {1'b0, total_w})
    else $error("Execution length differs from state count.");
  a_done_pulse: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    done_out |=> !done_out)
    else $error("Done held longer than one cycle.");
  a_high_keeps: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    done_out
      |-> rsp_out.dword_result[15:0] == req.dword_register[15:0])
    else $error("High-word load disturbed low half.");
  a_sign_ext: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (done_out && req.op == MVTIM_OP_SIGN_EXT)
      |-> rsp_out.word_result[15:8] == {8{gb[7]}})
    else $error("Sign extension wrong.");
  a_zero_ext: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (done_out && req.op == MVTIM_OP_ZERO_EXT)
      |-> rsp_out.word_result[15:8] == 8'h00)
    else $error("Zero extension wrong.");
  a_code_cost: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (done_out && is_code)
      |-> rsp_out.states == (req.ext_location
          ? 5'(5'h07 + wait_w) : 5'h06))
    else $error("Code read state count wrong.");
  a_xrd_cost: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (done_out && req.op == MVTIM_OP_XRD_DATA_POINTER_16)
      |-> rsp_out.states == (req.ext_location
          ? 5'(5'h05 + wait_w) : 5'h03))
    else $error("Pointer read state count wrong.");
  // Index-addressed external reads carry no wait-state addition at all.
  a_index_read_cost: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (done_out && req.op == MVTIM_OP_XRD_INDEX)
      |-> rsp_out.states == (req.source_mode ? 5'h05 : 5'h04))
    else $error("Index read state count wrong.");
  a_dirdir_cost: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (done_out && req.op == MVTIM_OP_DIR_DIR)
      |-> rsp_out.states == 5'(5'h03 + pen_a + pen_b))
    else $error("Direct-to-direct penalty wrong.");
  a_region_addr: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (done_out && x_any)
      |-> rsp_out.mem_address[23:16] == $past(region))
    else $error("External address outside selected region.");
  c_high_src: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    done_out && req.op == MVTIM_OP_HIGH_WORD && req.source_mode);
  c_ext_read: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    done_out && req.op == MVTIM_OP_XRD_DATA_POINTER_16 && req.ext_location);
  c_dir_dir: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    done_out && req.op == MVTIM_OP_DIR_DIR && req.dir_b == MVTIM_TGT_PERIPH);
  c_code_pc: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    done_out && req.op == MVTIM_OP_CODE_PC);
endmodule : mvtim_core

// *** bench/mvtim_mem_model.sv ***
`timescale 1ns/1ps
// Code and data memory as the core sees them on its byte inputs.
module mvtim_mem_model (
  input  wire logic        clock_in,
  input  wire logic        busy_in,
  input  wire logic [23:0] addr_in,
  output logic [7:0]       code_byte_out,
  output logic [7:0]       xdata_byte_out
);
  logic       scramble = 1'b0;
  logic [7:0] code_word;
  logic [7:0] data_word;

  // Data contents mix all address bits, code contents the low 16, so a wrong address reads a wrong byte.
  assign code_word = addr_in[7:0] ^ addr_in[15:8] ^ 8'h5A;
  assign data_word = addr_in[7:0] + addr_in[15:8] + addr_in[23:16];

  // Outside an access the bus never shows the true byte and changes every
  // cycle, so sampling at the wrong moment cannot match by luck.
  always @(posedge clock_in) begin
    scramble <= ~scramble;
  end
  assign code_byte_out  = busy_in ? code_word
                                  : ~code_word ^ {4{scramble, 1'b0}};
  assign xdata_byte_out = busy_in ? data_word
                                  : ~data_word ^ {4{scramble, 1'b0}};
endmodule : mvtim_mem_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import mvtim_pkg::*;
  localparam logic [3:0] WAITS = 4'h3;
  // Each entry: binary bytes, binary states, source bytes, source states.
  localparam logic [15:0] TIMING [25] = '{
    16'h5342, 16'h3221, 16'h3221, 16'h1616, 16'h1616, 16'h1415, 16'h1313,
    16'h1414, 16'h1414, 16'h1122, 16'h2121, 16'h1223, 16'h2121, 16'h1122,
    16'h2132, 16'h2132, 16'h2222, 16'h2233, 16'h3333, 16'h2334, 16'h3333,
    16'h1324, 16'h2334, 16'h2334, 16'h3232};
  logic        clock_in;
  logic        rst_n_in;
  logic        start_in;
  mvtim_req_t  req_in;
  logic        region_we_in;
  logic [7:0]  region_data_in;
  logic [7:0]  code_byte;
  logic [7:0]  xdata_byte;
  logic        busy_out;
  logic        done_out;
  logic [7:0]  region_out;
  mvtim_rsp_t  rsp_out;
  logic [23:0] mem_addr;
  logic [7:0]  region;
  mvtim_rsp_t  exp_q [$];
  mvtim_op_t   op_q [$];
  int          n_fail;
  int          comparisons;
  int          cnt;

  mvtim_core #(.WAIT_STATES_N(WAITS)) u_dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start_in),
    .req_in(req_in), .region_we_in(region_we_in),
    .region_data_in(region_data_in), .code_byte_in(code_byte),
    .xdata_byte_in(xdata_byte), .busy_out(busy_out), .done_out(done_out),
    .external_region_select_out(region_out), .rsp_out(rsp_out));
  mvtim_mem_model u_mem (
    .clock_in(clock_in), .busy_in(busy_out), .addr_in(mem_addr),
    .code_byte_out(code_byte), .xdata_byte_out(xdata_byte));

  // Half period of 25 ns gives the 20 MHz state clock.
  always #25 clock_in = ~clock_in;

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  function automatic logic [4:0] pen(input mvtim_tgt_t t);
    return (t == MVTIM_TGT_PORT) ? 5'h1
         : (t == MVTIM_TGT_PERIPH) ? 5'h2 : 5'h0;
  endfunction : pen

  // Notes the expected result, then issues one instruction and waits for
  // its end; a held start overlapping busy must be ignored.
  task automatic run(input mvtim_req_t r, input logic hold);
    logic [15:0] t;
    logic [15:0] base;
    mvtim_rsp_t  e;
    int          k;
    t = TIMING[r.op];
    e = '0;
    e.bytes = r.source_mode ? t[7:4] : t[15:12];
    e.states = {1'b0, r.source_mode ? t[3:0] : t[11:8]};
    if (r.op inside {MVTIM_OP_A_DIR, MVTIM_OP_REG_DIR, MVTIM_OP_DIR_A,
        MVTIM_OP_DIR_REG, MVTIM_OP_DIR_DIR, MVTIM_OP_DIR_IND,
        MVTIM_OP_DIR_IMM, MVTIM_OP_IND_DIR}) begin
      e.states += pen(r.dir_a);
    end
    if (r.op == MVTIM_OP_DIR_DIR) e.states += pen(r.dir_b);
    if (r.ext_location && r.op inside {MVTIM_OP_CODE_DATA_POINTER_16, MVTIM_OP_CODE_PC,
        MVTIM_OP_XWR_DATA_POINTER_16}) e.states += {1'b0, WAITS} + 5'h1;
    if (r.ext_location && r.op == MVTIM_OP_XRD_DATA_POINTER_16) begin
      e.states += {1'b0, WAITS} + 5'h2;
    end
    base = (r.op == MVTIM_OP_CODE_PC) ? r.program_counter : r.data_pointer_16;
    e.mem_address = {8'h00, base + {8'h00, r.accumulator}};
    if (r.op inside {MVTIM_OP_XRD_INDEX, MVTIM_OP_XWR_INDEX}) begin
      e.mem_address = {region, 8'h00, r.index_byte_register};
    end
    if (r.op inside {MVTIM_OP_XRD_DATA_POINTER_16, MVTIM_OP_XWR_DATA_POINTER_16}) begin
      e.mem_address = {region, r.data_pointer_16};
    end
    e.acc_result = r.accumulator;
    e.code_access = r.op inside {MVTIM_OP_CODE_DATA_POINTER_16, MVTIM_OP_CODE_PC};
    e.mem_write = r.op inside {MVTIM_OP_XWR_INDEX, MVTIM_OP_XWR_DATA_POINTER_16};
    if (e.code_access) begin
      e.acc_result = e.mem_address[7:0] ^ e.mem_address[15:8] ^ 8'h5A;
    end
    if (r.op inside {MVTIM_OP_XRD_INDEX, MVTIM_OP_XRD_DATA_POINTER_16}) begin
      e.acc_result = e.mem_address[7:0] + e.mem_address[15:8]
                     + e.mem_address[23:16];
    end
    e.dword_result = {r.immediate, r.dword_register[15:0]};
    e.word_result = {(r.op == MVTIM_OP_SIGN_EXT) ?
                     {8{r.general_byte_register[7]}} : 8'h00,
                     r.general_byte_register};
    exp_q.push_back(e);
    op_q.push_back(r.op);
    start_in <= 1'b1;
    req_in <= r;
    mem_addr <= e.mem_address;
    @(posedge clock_in);
    if (hold) @(posedge clock_in);
    start_in <= 1'b0;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (done_out !== 1'b1 && k < 64);
  endtask : run

  // Takes the oldest note whenever a result appears; cnt measures states
  // from the taking edge.
  always @(posedge clock_in) begin
    mvtim_rsp_t e;
    mvtim_op_t  op;
    if (done_out === 1'b1) begin
      e = exp_q.pop_front();
      op = op_q.pop_front();
      chk("latency", cnt, e.states);
      chk("busy", busy_out, 1'b1);
      chk("states", rsp_out.states, e.states);
      chk("bytes", rsp_out.bytes, e.bytes);
      chk("acc", rsp_out.acc_result, e.acc_result);
      if (op == MVTIM_OP_HIGH_WORD) begin
        chk("dword", rsp_out.dword_result, e.dword_result);
      end
      if (op inside {MVTIM_OP_SIGN_EXT, MVTIM_OP_ZERO_EXT}) begin
        chk("word", rsp_out.word_result, e.word_result);
      end
      if (op >= MVTIM_OP_CODE_DATA_POINTER_16 && op <= MVTIM_OP_XWR_DATA_POINTER_16) begin
        chk("addr", rsp_out.mem_address & (e.code_access ? 24'h00FFFF
            : 24'hFFFFFF), e.mem_address);
        chk("kind", {rsp_out.code_access, rsp_out.mem_write},
            {e.code_access, e.mem_write});
      end
    end
    if (start_in && busy_out === 1'b0) cnt = 0;
    else cnt++;
  end

  // Watchdog sized well above two passes of every form.
  initial begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    conclude();
  end

  initial begin
    mvtim_req_t   r;
    logic [159:0] bits;
    clock_in = 1'b0;
    rst_n_in = 1'b0;
    start_in = 1'b0;
    req_in = '0;
    region_we_in = 1'b0;
    region_data_in = 8'h00;
    mem_addr = 24'h000000;
    region = 8'h01;
    n_fail = 0;
    comparisons = 0;
    cnt = 0;
    void'($urandom(32'h4dfb));
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    chk("region reset", region_out, 8'h01);
    for (int pass = 0; pass < 2; pass++) begin
      for (int i = 0; i < 100; i++) begin
        bits = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
        r = bits[$bits(mvtim_req_t)-1:0];
        r.op = mvtim_op_t'(5'(i / 4));
        r.source_mode = i[0];
        r.ext_location = i[1];
        r.dir_a = mvtim_tgt_t'(2'($urandom_range(2)));
        r.dir_b = mvtim_tgt_t'(2'($urandom_range(2)));
        if (i[1]) r.program_counter[15:8] = 8'hFF;
        run(r, 1'($urandom_range(1)));
      end
      // Move to a fresh region between passes; the old one must not linger.
      region = 8'($urandom());
      region_data_in <= region;
      region_we_in <= 1'b1;
      @(posedge clock_in);
      region_we_in <= 1'b0;
      @(posedge clock_in);
      chk("region write", region_out, region);
    end
    repeat (4) @(posedge clock_in);
    chk("pending", exp_q.size(), 0);
    conclude();
  end
endmodule : testbench
